// ---- logic/scf_top.sv ----
// Purpose: Status flags and buffer handshake of a multi-mode serial unit
// Assumes: Serial clock and link events come from outside and are synchronised
// Notes:   Link clock is sampled by CLK; edges found in CLK domain
`timescale 1ns/100ps
`include "scf_cfg.svh"
module scf_top #(
    parameter int DATA_W = `SCF_DATA_W,
    parameter int DEPTH  = `SCF_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic               CLK,
    input  wire logic               RESET_N,
    input  wire logic               CE,
    // Configuration
    input  wire scf_pkg::scf_mode_t MODE,
    input  wire scf_pkg::scf_src_t  CLOCK_SOURCE_SEL,
    input  wire logic               SPI_CLOCK_PHASE_SEL,
    input  wire logic               SPI_CLOCK_POLARITY_SEL,
    // Candidate bit clocks (sampled)
    input  wire logic               LOW_FREQ_CRYSTAL_CLOCK,
    input  wire logic               SUBSYSTEM_CLOCK,
    input  wire logic               EXTERNAL_CLOCK_INPUT,
    // Serial link
    input  wire logic               SERIAL_CLOCK_IN,
    input  wire logic               SERIAL_DATA_IN,
    input  wire logic               UART_STOP_BIT,
    // Software side
    input  wire logic               RECEIVE_BUFFER_READ,
    output logic [DATA_W-1:0]       RECEIVE_BUFFER,
    input  wire logic               TRANSMIT_BUFFER_WRITE,
    input  wire logic               TRANSMIT_DONE,
    // Status
    output logic                    RECEIVE_WRITTEN_FLAG,
    output logic                    BUS_STALL,
    output logic                    CLOCK_LINE_LOW_FLAG,
    output logic                    STALL_CONFIRMED,
    output logic                    UNIT_BUSY_FLAG,
    output logic                    CLOCK_REQUEST,
    output logic                    TRANSMIT_READY_FLAG,
    output logic                    RECEIVE_READY_FLAG,
    output logic                    TRANSMIT_COMPLETE_FLAG,
    output logic                    FIFO_OVERFLOW
);
    import scf_pkg::*;

    typedef struct packed {
        logic [1:0]        rst_sync;
        logic [1:0]        scl_s1;
        logic [1:0]        scl_s2;
        logic [1:0]        sda_sync;
        logic [1:0]        stop_sync;
        logic [2:0]        src_s1;
        logic [2:0]        src_s2;
        logic              scl_prev;
        logic              bit_prev;
        logic              stop_prev;
        logic [2:0]        bit_cnt;
        logic [DATA_W-1:0] shift;
        logic              written;
        logic              stall;
        logic [3:0]        low_bits;
        logic              confirmed;
        logic              busy;
        logic              tx_full;
        logic              tx_cplt;
        logic [DATA_W-1:0] rx_data;
        logic              ovf;
        logic              push;
        logic              rx_rdy;
    } scf_st_t;

    scf_st_t st_ff, nxt_st;
    logic              rst_n;
    logic              fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    ////////////////////////////////////////////////////////////////////////
    // Bit clock selection among the sampled sources
    function automatic logic pick_clk(input scf_src_t s, input logic [2:0] c);
        case (s)
            `SCF_SRC_CRYSTAL:   pick_clk = c[0];
            `SCF_SRC_SUBSYSTEM: pick_clk = c[1];
            `SCF_SRC_EXTERNAL:  pick_clk = c[2];
            default:            pick_clk = c[1];
        endcase
    endfunction

    // Active SPI edge: polarity inverts idle level, phase picks second edge
    function automatic logic spi_sample_edge(input logic prev, input logic cur,
                                             input logic cpha, input logic cpol);
        logic lead;
        lead = (cur != prev) && ((cur ^ cpol) == 1'b1);
        spi_sample_edge = cpha ? ((cur != prev) && !lead) : lead;
    endfunction

    assign rst_n = st_ff.rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO: drained by buffer reads, fill on full drops the byte and sets overflow
    scf_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
        .clk       (CLK),
        .rst_n     (rst_n),
        .ce        (CE),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (st_ff.shift),
        .out_valid (fifo_out_valid),
        .out_ready (RECEIVE_BUFFER_READ),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic scl, scl_fall, bit_clk, bit_rise, byte_done, stop_rise, edge_hit;
        scl = 1'b0;
        scl_fall = 1'b0;
        bit_clk = 1'b0;
        bit_rise = 1'b0;
        byte_done = 1'b0;
        stop_rise = 1'b0;
        edge_hit = 1'b0;
        nxt_st = st_ff;
        nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
        nxt_st.scl_s1 = {st_ff.scl_s1[0], SERIAL_CLOCK_IN};
        nxt_st.scl_s2 = {st_ff.scl_s2[0], st_ff.scl_s1[1]};
        nxt_st.sda_sync = {st_ff.sda_sync[0], SERIAL_DATA_IN};
        nxt_st.stop_sync = {st_ff.stop_sync[0], UART_STOP_BIT};
        nxt_st.src_s1 = {EXTERNAL_CLOCK_INPUT, SUBSYSTEM_CLOCK, LOW_FREQ_CRYSTAL_CLOCK};
        nxt_st.src_s2 = st_ff.src_s1;
        scl = st_ff.scl_s2[0];
        nxt_st.scl_prev = scl;
        scl_fall = st_ff.scl_prev && !scl;
        bit_clk = pick_clk(CLOCK_SOURCE_SEL, st_ff.src_s2);
        nxt_st.bit_prev = bit_clk;
        bit_rise = bit_clk && !st_ff.bit_prev;
        nxt_st.stop_prev = st_ff.stop_sync[1];
        stop_rise = st_ff.stop_sync[1] && !st_ff.stop_prev;

        // Shift in on the mode's sampling edge
        if (MODE == SCF_MODE_SPI) begin
            edge_hit = spi_sample_edge(st_ff.scl_prev, scl, SPI_CLOCK_PHASE_SEL, SPI_CLOCK_POLARITY_SEL);
        end else begin
            edge_hit = !st_ff.scl_prev && scl;
        end
        if (edge_hit && !st_ff.stall) begin
            nxt_st.shift = {st_ff.shift[DATA_W-2:0], st_ff.sda_sync[1]};
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            nxt_st.busy = 1'b1;
            byte_done = (st_ff.bit_cnt == 3'h7);
        end
        if (byte_done) begin
            nxt_st.busy = 1'b0;
        end

        // Written flag: read clear applied before edge set, no clear lost
        if (RECEIVE_BUFFER_READ) begin
            nxt_st.written = 1'b0;
            nxt_st.stall = 1'b0;
        end
        if (MODE == SCF_MODE_I2C && scl_fall && !RECEIVE_BUFFER_READ) begin
            nxt_st.written = 1'b1;
        end
        // Stall when a new byte starts while the last one is still unread
        if (MODE == SCF_MODE_I2C && scl_fall && st_ff.bit_cnt == 3'h0 && st_ff.written
            && !RECEIVE_BUFFER_READ) begin
            nxt_st.stall = 1'b1;
        end

        // Count bit clocks while the line stays low
        if (scl) begin
            nxt_st.low_bits = '0;
            nxt_st.confirmed = 1'b0;
        end else if (bit_rise && st_ff.low_bits != `SCF_STALL_BITS) begin
            nxt_st.low_bits = st_ff.low_bits + 4'h1;
        end
        if (!scl && st_ff.low_bits == `SCF_STALL_BITS) begin
            nxt_st.confirmed = 1'b1;
        end

        // Transmit side: complete only when the buffer is empty
        if (TRANSMIT_BUFFER_WRITE) begin
            nxt_st.tx_full = 1'b1;
            nxt_st.tx_cplt = 1'b0;
        end else if (TRANSMIT_DONE) begin
            nxt_st.tx_full = 1'b0;
        end
        if (MODE == SCF_MODE_UART && stop_rise && !st_ff.tx_full && !TRANSMIT_BUFFER_WRITE) begin
            nxt_st.tx_cplt = 1'b1;
        end

        // Overflow is sticky; full FIFO refuses the byte
        nxt_st.push = byte_done;
        if (st_ff.push && !fifo_in_ready) begin
            nxt_st.ovf = 1'b1;
        end
        nxt_st.rx_data = fifo_out_valid ? fifo_out_data : st_ff.rx_data;
        nxt_st.rx_rdy = fifo_out_valid;
    end

    // Completed byte is offered for one cycle after its last bit
    assign fifo_in_valid = st_ff.push;

    ////////////////////////////////////////////////////////////////////////
    // State register; reset release goes through two flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff          <= '0;
            // Clock and data lines idle high: no false edge after reset
            st_ff.scl_s1   <= 2'b11;
            st_ff.scl_s2   <= 2'b11;
            st_ff.scl_prev <= 1'b1;
            st_ff.sda_sync <= 2'b11;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign RECEIVE_BUFFER         = st_ff.rx_data;
    assign RECEIVE_WRITTEN_FLAG   = st_ff.written;
    assign BUS_STALL              = st_ff.stall;
    assign CLOCK_LINE_LOW_FLAG    = !st_ff.scl_prev;
    assign STALL_CONFIRMED        = st_ff.confirmed;
    assign UNIT_BUSY_FLAG         = st_ff.busy;
    assign CLOCK_REQUEST          = st_ff.busy;
    assign TRANSMIT_READY_FLAG    = !st_ff.tx_full;
    assign RECEIVE_READY_FLAG     = st_ff.rx_rdy;
    assign TRANSMIT_COMPLETE_FLAG = st_ff.tx_cplt;
    assign FIFO_OVERFLOW          = st_ff.ovf;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    written_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
        CE && RECEIVE_BUFFER_READ |=> !st_ff.written) else $error("read clear lost");
    written_fall_a: assert property (@(posedge CLK) disable iff (!rst_n)
        CE && MODE == SCF_MODE_I2C && st_ff.scl_prev && !st_ff.scl_s2[0] && !RECEIVE_BUFFER_READ
        |=> st_ff.written) else $error("fall did not set flag");
    stall_cause_a: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(st_ff.stall) |-> $past(st_ff.written)) else $error("stall without flag");
    confirm_count_a: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(st_ff.confirmed) |-> $past(st_ff.low_bits) == `SCF_STALL_BITS) else $error("early confirm");
    confirm_low_a: assert property (@(posedge CLK) disable iff (!rst_n)
        st_ff.confirmed |-> !st_ff.scl_prev || $past(!st_ff.scl_prev)) else $error("confirm while high");
    clk_req_a: assert property (@(posedge CLK) disable iff (!rst_n)
        CLOCK_REQUEST == UNIT_BUSY_FLAG) else $error("request mismatch");
    busy_end_a: assert property (@(posedge CLK) disable iff (!rst_n)
        st_ff.push |-> !UNIT_BUSY_FLAG && !CLOCK_REQUEST) else $error("busy after byte");
    cplt_empty_a: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(st_ff.tx_cplt) |-> $past(!st_ff.tx_full)) else $error("complete with data");
    tx_ready_a: assert property (@(posedge CLK) disable iff (!rst_n)
        CE && TRANSMIT_BUFFER_WRITE |=> !TRANSMIT_READY_FLAG) else $error("ready not cleared");
endmodule

// ---- logic/scf_cfg.svh ----
// Purpose: Constants for the serial flag logic block
// Assumes: 250 MHz system clock
// Notes:   Included by the package and the top module
//
// What this block does
// - Falling serial clock edge in I2C mode sets the receive-written flag.
// - Receive buffer read clears the flag; flag set at next byte stalls the bus.
// - Clock-low flag follows line low; stall confirmed after three bit clocks low.
// - Bit clock source selectable: crystal clock, subsystem clock or external input.
// - Phase and polarity bits select all four SPI clock modes.
// - Clock request follows busy; busy clears when the transfer ends.
// - Transmit and receive ready flags show buffer empty and data available.
// - Transmit complete rises at last stop bit only when transmit buffer empty.
// - Register accesses win over a link event in the same cycle: the flag being set ends up clear.
`ifndef SCF_CFG_SVH
`define SCF_CFG_SVH
`define SCF_STALL_BITS     4'h3
`define SCF_SRC_CRYSTAL    2'h0
`define SCF_SRC_SUBSYSTEM  2'h1
`define SCF_SRC_EXTERNAL   2'h2
`define SCF_FIFO_DEPTH     32
`define SCF_DATA_W         8
`endif

// ---- logic/scf_pkg.sv ----
// Purpose: Types for the serial flag logic block
// Assumes: scf_cfg.svh holds the numbers
// Notes:   Mode and clock source encodings
`include "scf_cfg.svh"
package scf_pkg;
    typedef enum logic [2:0] {
        SCF_MODE_I2C  = 3'b001,
        SCF_MODE_SPI  = 3'b010,
        SCF_MODE_UART = 3'b100
    } scf_mode_t;
    typedef logic [1:0] scf_src_t;
endpackage

// ---- logic/scf_fifo.sv ----
// Purpose: Receive data FIFO with valid/ready on both sides
// Assumes: Single clock, clock enable freezes state
// Notes:   Storage is flip-flops addressed by index
`timescale 1ns/100ps
module scf_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [AW:0]         cnt;
    } scf_fifo_st_t;
    scf_fifo_st_t st_ff, nxt_st;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Honest full and empty from the count
    assign in_ready  = (st_ff.cnt != (AW+1)'(D)); // Count is one bit wider so a full FIFO reads as D
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(D - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(D - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ---- test/scf_link_peer.sv ----
// Purpose: Serial link peer driving clock, data and stop bit
// Assumes: Clock line idles high and stands still between frames
// Notes:   Released data line shows its pull-up level
`timescale 1ns/100ps
module scf_link_peer #(
    parameter int HALF = 80
) (
    // Link lines
    output logic scl,
    output logic sda,
    output logic stop
);
    ////////////////////////////////////////////////////////////
    // Idle levels before any frame
    initial begin
        scl  = 1'b1;
        sda  = 1'b1;
        stop = 1'b0;
    end
    // One byte MSB first, data bits change while the clock is low; data is released with the clock high
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            sda = b[i];
            #HALF;
            scl = 1'b1;
            #HALF;
        end
        sda = 1'b1; // Released: pull-up level
    endtask
    // Hold the clock low to stall, or let it go high again
    task automatic hold_low(input logic v);
        scl = !v;
    endtask
    // Stop bit of one character
    task automatic stop_bit();
        stop = 1'b1;
        #(2*HALF);
        stop = 1'b0;
    endtask
endmodule

// ---- test/scf_top_bench.sv ----
// Purpose: Self-checking bench for the serial flag logic
// Assumes: Peer model drives the link, bench drives the software side
// Notes:   Expected values come from queues and the flag rules
`timescale 1ns/100ps
`include "scf_cfg.svh"
module scf_top_bench;
    import scf_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        rd = 1'b0, wr = 1'b0, done = 1'b0, cph = 1'b0, cpl = 1'b0;
    logic [2:0]  bclk = 3'h0;
    scf_mode_t   mode = SCF_MODE_I2C;
    scf_src_t    src = `SCF_SRC_CRYSTAL;
    logic [7:0]  rxb;
    logic        wflag, stall, low, conf, busy, creq, txr, rxr, txc, ovf, scl, sda, stp;
    logic        ce = 1'b1;
    int          n;
    logic [15:0] lfsr = 16'h1e3e;  // 7742
    logic [7:0]  q[$];
    int          errors = 0;
    int          comparisons = 0;
    ////////////////////////////////////////////////////////////
    // 250 MHz system clock
    always #2 clk = ~clk;
    scf_top u_scf_top (.CLK(clk), .RESET_N(reset_n), .CE(ce), .MODE(mode), .CLOCK_SOURCE_SEL(src),
        .SPI_CLOCK_PHASE_SEL(cph), .SPI_CLOCK_POLARITY_SEL(cpl), .LOW_FREQ_CRYSTAL_CLOCK(bclk[0]),
        .SUBSYSTEM_CLOCK(bclk[1]), .EXTERNAL_CLOCK_INPUT(bclk[2]), .SERIAL_CLOCK_IN(scl),
        .SERIAL_DATA_IN(sda), .UART_STOP_BIT(stp), .RECEIVE_BUFFER_READ(rd), .RECEIVE_BUFFER(rxb),
        .TRANSMIT_BUFFER_WRITE(wr), .TRANSMIT_DONE(done), .RECEIVE_WRITTEN_FLAG(wflag), .BUS_STALL(stall),
        .CLOCK_LINE_LOW_FLAG(low), .STALL_CONFIRMED(conf), .UNIT_BUSY_FLAG(busy), .CLOCK_REQUEST(creq),
        .TRANSMIT_READY_FLAG(txr), .RECEIVE_READY_FLAG(rxr), .TRANSMIT_COMPLETE_FLAG(txc),
        .FIFO_OVERFLOW(ovf));
    scf_link_peer u_scf_link_peer (.scl(scl), .sda(sda), .stop(stp));
    ////////////////////////////////////////////////////////////
    // Pseudo-random source, shift with feedback taps
    function automatic logic [15:0] nxt_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Inputs always change 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    // Mid-run reset: clears byte alignment and the FIFO
    task automatic restart();
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        tick(4);
    endtask
    // Candidate bit clock, 40 ns period, keeps the 1 ns offset
    task automatic bit_clocks(input int i, input int n);
        repeat (n) begin
            bclk[i] = 1'b1;
            #20;
            bclk[i] = 1'b0;
            #20;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        tick(3);
        chk("reset written", wflag, 1'b0);
        chk("reset tx ready", txr, 1'b1);
        reset_n = 1'b1;
        tick(4);
        // Random byte in, read clears the written flag next cycle
        lfsr = nxt_rand(lfsr);
        q.push_back(lfsr[7:0]);
        u_scf_link_peer.send_byte(lfsr[7:0]);
        tick(8);
        chk("written", wflag, 1'b1);
        chk("rx byte", rxb, q.pop_front());
        pulse(rd);
        chk("written clear", wflag, 1'b0);
        // Second byte while unread stalls the bus, first does not
        u_scf_link_peer.send_byte(8'h5a);
        tick(8);
        chk("no stall", stall, 1'b0);
        u_scf_link_peer.send_byte(8'ha5);
        tick(8);
        chk("stall", stall, 1'b1);
        // Reset again in mid-run to start clean
        restart();
        // Read swept across the clock fall: the clear is never lost
        for (int k = 0; k < 8; k++) begin
            u_scf_link_peer.hold_low(1'b1);
            tick(k);
            pulse(rd);
            chk("read wins", wflag, 1'b0);
            u_scf_link_peer.hold_low(1'b0);
            tick(8);
        end
        // Stall confirm needs three edges of the selected source only
        for (int s = 0; s < 3; s++) begin
            src = scf_src_t'(s);
            u_scf_link_peer.hold_low(1'b1);
            tick(8);
            bit_clocks((s + 1) % 3, 6);
            chk("low flag", low, 1'b1);
            chk("other source", conf, 1'b0);
            bit_clocks(s, 2);
            tick(8);
            chk("two edges", conf, 1'b0);
            bit_clocks(s, 1);
            tick(8);
            chk("confirmed", conf, 1'b1);
            u_scf_link_peer.hold_low(1'b0);
            tick(8);
            chk("line high", low, 1'b0);
        end
        // All four phase and polarity modes; busy drops when done
        mode = SCF_MODE_SPI;
        restart();
        for (int c = 0; c < 4; c++) begin
            {cph, cpl} = c[1:0];
            lfsr = nxt_rand(lfsr);
            pulse(wr);
            chk("tx full", txr, 1'b0);
            fork
                u_scf_link_peer.send_byte(lfsr[7:0]);
                begin
                    tick(60);
                    chk("busy", busy, 1'b1);
                    chk("request", creq, 1'b1);
                end
            join
            tick(8);
            chk("busy clear", busy, 1'b0);
            chk("request off", creq, 1'b0);
            chk("spi byte", rxb, lfsr[7:0]);
            pulse(rd);
            pulse(done);
            tick(2);
            chk("tx empty", txr, 1'b1);
        end
        // Clock enable low freezes state: a write is ignored
        ce = 1'b0;
        pulse(wr);
        ce = 1'b1;
        tick(1);
        chk("frozen", txr, 1'b1);
        // Complete only at a stop bit with an empty buffer
        mode = SCF_MODE_UART;
        pulse(wr);
        tick(1);
        u_scf_link_peer.stop_bit();
        tick(8);
        chk("not complete", txc, 1'b0);
        pulse(done);
        tick(1);
        u_scf_link_peer.stop_bit();
        tick(8);
        chk("complete", txc, 1'b1);
        // Reads during a link event leave the flags set
        fork
            u_scf_link_peer.stop_bit();
            repeat (20) begin
                pulse(rd);
                tick(1);
            end
        join
        tick(8);
        chk("complete kept", txc, 1'b1);
        chk("ready kept", txr, 1'b1);
        // FIFO filled over the link one byte past full, drained with random gaps
        mode = SCF_MODE_SPI;
        {cph, cpl} = 2'b00;
        restart();
        q.delete();
        for (int i = 0; i < 33; i++) begin
            lfsr = nxt_rand(lfsr);
            if (i < 32) q.push_back(lfsr[7:0]);
            u_scf_link_peer.send_byte(lfsr[7:0]);
        end
        tick(8);
        chk("overflow", ovf, 1'b1);
        chk("rx ready", rxr, 1'b1);
        n = 0;
        for (int i = 0; i < 40 && rxr === 1'b1; i++) begin
            chk("fifo data", rxb, (q.size() > 0) ? q.pop_front() : 8'h00);
            n++;
            pulse(rd);
            lfsr = nxt_rand(lfsr);
            tick(1 + int'(lfsr[1:0]));
        end
        chk("fifo depth", 8'(n), 8'd32);
        chk("fifo empty", rxr, 1'b0);
        finish_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        errors++;
        finish_test();
    end
endmodule
